// >>> pkg/dmc_pkg.sv
// Package with register map, field layouts and shared types of the DMA channel block.
// Contract
// - Second instance has five working channels only.
// - Channel control register at 0x08 plus 0x14x.
// - Flags set by hardware, cleared by clears.
// - Error flag at bit 4x+3 on errors.
// - Half flag at 4x+2 at half count.
// - Done flag at 4x+1 at full count.
// - Any-event bit 4x ORs the three flags.
// - Clear bit one clears its flag only.
// - Any-event clear clears all four flags.
// - Bit 14 selects memory-to-memory copying.
// - Bits 13:12 give channel rank.
// - Bits 11:10 give memory item size.
// - Bits 9:8 give peripheral item size.
// - Bit 7 steps memory address.
// - Bit 6 steps peripheral address.
// - Bit 5 enables ring reload.
// - Bit 4 selects copy direction.
// - Bits 3:1 allow error, half, done interrupts.
// - Setup fields locked while channel is on.
// - Per-channel interrupt from allowed set flags.
// - Counter decrements; zero count issues nothing.
// - Ring mode reloads count, sets done.
// - Increment step is 1, 2 or 4.
`default_nettype none
package dmc_pkg;

   // Register offsets within the block, and the per-channel stride.
   localparam logic [11:0] OFS_FLAGS = 12'h000;
   localparam logic [11:0] OFS_CLEAR = 12'h004;
   localparam logic [11:0] OFS_CTL   = 12'h008;
   localparam logic [11:0] OFS_CNT   = 12'h00C;
   localparam logic [11:0] OFS_PADDR = 12'h010;
   localparam logic [11:0] OFS_MADDR = 12'h014;
   localparam logic [11:0] CH_STRIDE = 12'h014;

   // Flag and clear word layout: four bits per channel.
   localparam int FLAG_STRIDE = 4;
   localparam int BIT_ANY     = 0;
   localparam int BIT_DONE    = 1;
   localparam int BIT_HALF    = 2;
   localparam int BIT_ERR     = 3;

   // Reset values of all registers.
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] RESET_CNT  = 16'h0000;

   // Item size encodings; the fourth code is reserved.
   localparam logic [1:0] SIZE_8  = 2'h0;
   localparam logic [1:0] SIZE_16 = 2'h1;
   localparam logic [1:0] SIZE_32 = 2'h2;

   // Channel setup word, bits 14:0 in printed order.
   typedef struct packed {
      logic       mem_copy_mode;
      logic [1:0] channel_rank;
      logic [1:0] memory_item_size;
      logic [1:0] periph_item_size;
      logic       memory_addr_step;
      logic       periph_addr_step;
      logic       ring_reload;
      logic       copy_orientation;
      logic       error_irq_allow;
      logic       half_done_irq_allow;
      logic       all_done_irq_allow;
      logic       channel_on;
   } dmc_ctl_t;

   // One item move handed to the data mover.
   typedef struct packed {
      logic [31:0] src_addr;
      logic [31:0] dst_addr;
      logic [1:0]  src_size;
      logic [1:0]  dst_size;
      logic [2:0]  channel;
   } dmc_xfer_t;

   // Engine states.
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } dmc_state_t;

endpackage
`default_nettype wire

// >>> design/dmc_top.sv
// DMA channel control, event flags, arbitration and AHB-Lite register slave.
//
// Our own choice: the AHB-Lite slave port.
`default_nettype none
module dmc_top #(
   parameter int NUM_CH = 7
) (
   input  wire logic              clock,       // System clock, 250 MHz.
   input  wire logic              reset,       // Synchronous reset, active high.
   input  wire logic              hsel,        // Slave select.
   input  wire logic [31:0]       haddr,       // Byte address.
   input  wire logic [1:0]        htrans,      // Transfer type.
   input  wire logic              hwrite,      // Write when high.
   input  wire logic [2:0]        hsize,       // Transfer size, words only.
   input  wire logic [31:0]       hwdata,      // Write data.
   input  wire logic              hready,      // Bus ready.
   output logic                   hreadyout,   // Slave ready, always high.
   output logic [31:0]            hrdata,      // Read data.
   output logic                   hresp,       // Response, always OKAY.
   input  wire logic [NUM_CH-1:0] periph_req,  // Peripheral requests, same clock.
   output logic                   xfer_valid,  // Item move pending.
   output dmc_pkg::dmc_xfer_t     xfer_req,    // Item move description.
   input  wire logic              xfer_done,   // Item move finished well.
   input  wire logic              xfer_error,  // Item move hit a bus error.
   output logic [NUM_CH-1:0]      irq          // Per-channel interrupt lines.
);

   // Per-channel state.
   dmc_pkg::dmc_ctl_t ctl      [NUM_CH];
   logic [15:0]       prog_cnt [NUM_CH];
   logic [15:0]       cnt      [NUM_CH];
   logic [31:0]       pbase    [NUM_CH];
   logic [31:0]       mbase    [NUM_CH];
   logic [31:0]       pcur     [NUM_CH];
   logic [31:0]       mcur     [NUM_CH];
   logic [2:0]        flg      [NUM_CH];  // {error_seen, half_done, all_done}.

   dmc_pkg::dmc_state_t state;
   logic [2:0]          cur_ch;
   logic                wr_pend;
   logic [11:0]         wr_addr;
   logic [31:0]         flag_word;
   logic [31:0]         rd_val;
   logic                found;
   logic [2:0]          best;
   logic [1:0]          best_rank;
   logic                fin_ok;
   logic                fin_err;

   wire addr_ok = hsel & htrans[1] & hready;

   // Address step per item size; the reserved code steps as a word.
   function automatic logic [31:0] step_of(input logic [1:0] size);
      case (size)
         dmc_pkg::SIZE_8:  step_of = 32'h0000_0001;
         dmc_pkg::SIZE_16: step_of = 32'h0000_0002;
         default:          step_of = 32'h0000_0004;
      endcase
   endfunction

   // Offset of a per-channel register for channel i.
   function automatic logic [11:0] ch_ofs(input logic [11:0] base, input int i);
      ch_ofs = 12'(base + dmc_pkg::CH_STRIDE * 12'(i));
   endfunction

   // Flag word; any_event is derived so it can never disagree with the others.
   always_comb begin
      flag_word = dmc_pkg::RESET_WORD;
      for (int i = 0; i < NUM_CH; i++) begin
         flag_word[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_ERR]  = flg[i][2];
         flag_word[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_HALF] = flg[i][1];
         flag_word[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_DONE] = flg[i][0];
         flag_word[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_ANY]  = |flg[i];
      end
   end

   // Read decode; unmapped offsets and the write-only clear word read as zero.
   always_comb begin
      rd_val = dmc_pkg::RESET_WORD;
      if (haddr[11:0] == dmc_pkg::OFS_FLAGS) begin
         rd_val = flag_word;
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (haddr[11:0] == ch_ofs(dmc_pkg::OFS_CTL, i)) begin
            rd_val = {17'h0_0000, ctl[i]};
         end
         if (haddr[11:0] == ch_ofs(dmc_pkg::OFS_CNT, i)) begin
            rd_val = {16'h0000, cnt[i]};
         end
         if (haddr[11:0] == ch_ofs(dmc_pkg::OFS_PADDR, i)) begin
            rd_val = pbase[i];
         end
         if (haddr[11:0] == ch_ofs(dmc_pkg::OFS_MADDR, i)) begin
            rd_val = mbase[i];
         end
      end
   end

   // AHB-Lite address phase capture and read data; the slave never waits.
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 12'h000;
         hrdata    <= dmc_pkg::RESET_WORD;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend   <= addr_ok & hwrite;
         wr_addr   <= haddr[11:0];
         hrdata    <= (addr_ok & ~hwrite) ? rd_val : dmc_pkg::RESET_WORD;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Arbitration among pending channels.
   always_comb begin
      found     = 1'b0;
      best      = 3'h0;
      best_rank = 2'h0;
      for (int i = 0; i < NUM_CH; i++) begin
         // Zero count never asks, enabled or not.
         if (ctl[i].channel_on && cnt[i] != 16'h0000 &&
             (ctl[i].mem_copy_mode || periph_req[i])) begin
            // Strict greater-than keeps the lower index on equal rank.
            if (!found || ctl[i].channel_rank > best_rank) begin
               found     = 1'b1;
               best      = 3'(i);
               best_rank = ctl[i].channel_rank;
            end
         end
      end
   end

   assign fin_ok  = (state == dmc_pkg::ST_BUSY) & xfer_done & ~xfer_error;
   assign fin_err = (state == dmc_pkg::ST_BUSY) & xfer_error;

   // Engine: one item at a time, held until the mover answers.
   always_ff @(posedge clock) begin
      if (reset) begin
         state      <= dmc_pkg::ST_IDLE;
         cur_ch     <= 3'h0;
         xfer_valid <= 1'b0;
         xfer_req   <= '0;
      end else begin
         case (state)
            dmc_pkg::ST_IDLE: begin
               if (found) begin
                  state      <= dmc_pkg::ST_BUSY;
                  cur_ch     <= best;
                  xfer_valid <= 1'b1;
                  xfer_req.channel <= best;
                  if (ctl[best].copy_orientation) begin
                     xfer_req.src_addr <= mcur[best];
                     xfer_req.dst_addr <= pcur[best];
                     xfer_req.src_size <= ctl[best].memory_item_size;
                     xfer_req.dst_size <= ctl[best].periph_item_size;
                  end else begin
                     xfer_req.src_addr <= pcur[best];
                     xfer_req.dst_addr <= mcur[best];
                     xfer_req.src_size <= ctl[best].periph_item_size;
                     xfer_req.dst_size <= ctl[best].memory_item_size;
                  end
               end
            end
            dmc_pkg::ST_BUSY: begin
               if (xfer_done || xfer_error) begin
                  state      <= dmc_pkg::ST_IDLE;
                  xfer_valid <= 1'b0;
               end
            end
            default: begin
               state      <= dmc_pkg::ST_IDLE;
               xfer_valid <= 1'b0;
            end
         endcase
      end
   end

   // Channel registers: software writes, then hardware progress which wins.
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ctl[i]      <= '0;
            prog_cnt[i] <= dmc_pkg::RESET_CNT;
            cnt[i]      <= dmc_pkg::RESET_CNT;
            pbase[i]    <= dmc_pkg::RESET_WORD;
            mbase[i]    <= dmc_pkg::RESET_WORD;
            pcur[i]     <= dmc_pkg::RESET_WORD;
            mcur[i]     <= dmc_pkg::RESET_WORD;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_pend && wr_addr == ch_ofs(dmc_pkg::OFS_CTL, i)) begin
               if (ctl[i].channel_on) begin
                  // Only the interrupt allows and the enable stay writable.
                  ctl[i].error_irq_allow     <= hwdata[3];
                  ctl[i].half_done_irq_allow <= hwdata[2];
                  ctl[i].all_done_irq_allow  <= hwdata[1];
                  ctl[i].channel_on          <= hwdata[0];
               end else begin
                  ctl[i] <= hwdata[14:0];
               end
            end
            // Count and addresses are frozen while the channel runs.
            if (wr_pend && !ctl[i].channel_on) begin
               if (wr_addr == ch_ofs(dmc_pkg::OFS_CNT, i)) begin
                  prog_cnt[i] <= hwdata[15:0];
                  cnt[i]      <= hwdata[15:0];
               end
               if (wr_addr == ch_ofs(dmc_pkg::OFS_PADDR, i)) begin
                  pbase[i] <= hwdata;
                  pcur[i]  <= hwdata;
               end
               if (wr_addr == ch_ofs(dmc_pkg::OFS_MADDR, i)) begin
                  mbase[i] <= hwdata;
                  mcur[i]  <= hwdata;
               end
            end
            if (fin_err && cur_ch == 3'(i)) begin
               ctl[i].channel_on <= 1'b0;
            end
            if (fin_ok && cur_ch == 3'(i)) begin
               if (cnt[i] == 16'h0001 && ctl[i].ring_reload) begin
                  // Ring mode restarts from the programmed count and bases.
                  cnt[i]  <= prog_cnt[i];
                  pcur[i] <= pbase[i];
                  mcur[i] <= mbase[i];
               end else begin
                  cnt[i] <= cnt[i] - 16'h0001;
                  if (ctl[i].periph_addr_step) begin
                     pcur[i] <= pcur[i] + step_of(ctl[i].periph_item_size);
                  end
                  if (ctl[i].memory_addr_step) begin
                     mcur[i] <= mcur[i] + step_of(ctl[i].memory_item_size);
                  end
               end
            end
         end
      end
   end

   // Event flags; a set in the same cycle as its clear survives.
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < NUM_CH; i++) begin
            flg[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            logic [2:0] clr;
            logic [2:0] set;
            logic [15:0] next_cnt;
            clr      = 3'h0;
            set      = 3'h0;
            next_cnt = cnt[i] - 16'h0001;
            // Writes to the flag word itself decode to nothing here.
            if (wr_pend && wr_addr == dmc_pkg::OFS_CLEAR) begin
               clr[2] = hwdata[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_ERR];
               clr[1] = hwdata[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_HALF];
               clr[0] = hwdata[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_DONE];
               if (hwdata[dmc_pkg::FLAG_STRIDE*i+dmc_pkg::BIT_ANY]) begin
                  clr = 3'h7;
               end
            end
            if (fin_err && cur_ch == 3'(i)) begin
               set[2] = 1'b1;
            end
            if (fin_ok && cur_ch == 3'(i)) begin
               set[1] = (next_cnt == (prog_cnt[i] >> 1));
               set[0] = (next_cnt == 16'h0000);
            end
            flg[i] <= (flg[i] & ~clr) | set;
         end
      end
   end

   // Interrupt lines, one per channel, a cycle behind the flags.
   always_ff @(posedge clock) begin
      if (reset) begin
         irq <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            irq[i] <= (flg[i][2] & ctl[i].error_irq_allow) |
                      (flg[i][1] & ctl[i].half_done_irq_allow) |
                      (flg[i][0] & ctl[i].all_done_irq_allow);
         end
      end
   end

endmodule
`default_nettype wire

// >>> tb/dmc_checker.sv
// Concurrent checks on the bus and mover ports of the DMA channel block.
`default_nettype none
module dmc_checker #(
   parameter int NUM_CH = 7
) (
   input wire logic               clock,      // System clock.
   input wire logic               reset,      // Synchronous reset.
   input wire logic               hsel,       // Slave select.
   input wire logic [31:0]        haddr,      // Byte address.
   input wire logic [1:0]         htrans,     // Transfer type.
   input wire logic               hwrite,     // Write when high.
   input wire logic               hready,     // Bus ready.
   input wire logic               hreadyout,  // Slave ready.
   input wire logic [31:0]        hrdata,     // Read data.
   input wire logic               hresp,      // Response.
   input wire logic               xfer_valid, // Item move pending.
   input wire dmc_pkg::dmc_xfer_t xfer_req,   // Item move description.
   input wire logic               xfer_done,  // Item finished.
   input wire logic               xfer_error, // Item failed.
   input wire logic [NUM_CH-1:0]  irq         // Interrupt lines.
);
   logic        rd_dp;
   logic [11:0] rd_a;
   logic [2:0]  act;
   logic        any_ok;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // Track read data phases, and recent causes that may move an interrupt line.
   always_ff @(posedge clock) begin
      rd_dp <= !reset && hsel && htrans[1] && hready && !hwrite;
      rd_a  <= haddr[11:0];
      act   <= {act[1:0], reset || (xfer_valid && (xfer_done || xfer_error)) || (hsel && htrans[1] && hwrite)};
   end
   // Each any-event bit must equal the OR of its channel's three event bits.
   always_comb begin
      any_ok = 1'b1;
      for (int k = 0; k < NUM_CH; k++) begin
         if (hrdata[4*k] != (|hrdata[4*k+1 +: 3]))
            any_ok = 1'b0;
      end
   end
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or not OKAY");
   chk_idle_zero: assert property (!rd_dp |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   chk_flag_any_or: assert property (rd_dp && rd_a == 12'h000 |-> any_ok && (hrdata >> (4*NUM_CH)) == 32'h0)
      else $error("flag word inconsistent");
   chk_clear_reads_zero: assert property (rd_dp && rd_a == 12'h004 |-> hrdata == 32'h0)
      else $error("clear word read not zero");
   chk_ctl_upper_zero: assert property (rd_dp && rd_a >= 12'h008 && (rd_a - 12'h008) % 12'h014 == 12'h000
      |-> hrdata[31:15] == 17'h0)
      else $error("control reserved bits set");
   chk_done_drops: assert property (xfer_valid && xfer_done |=> !xfer_valid)
      else $error("item still pending after done");
   chk_error_stops: assert property (xfer_valid && xfer_error |=> !xfer_valid)
      else $error("item still pending after error");
   chk_req_hold: assert property (xfer_valid && !xfer_done && !xfer_error |=> xfer_valid && $stable(xfer_req))
      else $error("item request moved before answer");
   chk_chan_range: assert property (xfer_valid |-> xfer_req.channel < NUM_CH)
      else $error("item for absent channel");
   chk_irq_cause: assert property ($changed(irq) |-> act != 3'h0)
      else $error("interrupt moved without cause");
   cover property (xfer_valid && xfer_error);
   cover property (rd_dp && rd_a == 12'h000);
   cover property ($rose(irq[0]));
endmodule
bind dmc_top dmc_checker #(.NUM_CH(NUM_CH)) u_dmc_checker (.clock, .reset, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hreadyout, .hrdata, .hresp, .xfer_valid, .xfer_req, .xfer_done, .xfer_error, .irq);
`default_nettype wire

// >>> tb/dmc_mover_model.sv
// Behavioural data mover that answers each item after a set delay.
`default_nettype none
module dmc_mover_model (
   input  wire logic       clock,      // System clock.
   input  wire logic       reset,      // Synchronous reset, active high.
   input  wire logic       xfer_valid, // Item move pending.
   input  wire logic [3:0] lag,        // Cycles to wait before answering.
   input  wire logic       fail,       // Answer with a bus error.
   output logic            xfer_done,  // Item finished well.
   output logic            xfer_error  // Item hit a bus error.
);
   logic [3:0] waited;
   // One pulse per item; the pulse clears itself so an item is never answered twice.
   always_ff @(posedge clock) begin
      if (reset || xfer_done || xfer_error) begin
         xfer_done  <= 1'b0;
         xfer_error <= 1'b0;
         waited     <= 4'h0;
      end else if (xfer_valid && waited == lag) begin
         xfer_done  <= !fail;
         xfer_error <= fail;
      end else if (xfer_valid) begin
         waited <= waited + 4'h1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench of the DMA channel block with a behavioural mover.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] FLG = dmc_pkg::OFS_FLAGS;
   localparam logic [11:0] CLR = dmc_pkg::OFS_CLEAR;
   localparam logic [11:0] CTL = dmc_pkg::OFS_CTL;
   localparam logic [11:0] CNT = dmc_pkg::OFS_CNT;
   localparam logic [11:0] PAD = dmc_pkg::OFS_PADDR;
   localparam logic [11:0] MAD = dmc_pkg::OFS_MADDR;
   logic               clock      = 1'b0;
   logic               reset      = 1'b1;
   logic               hsel       = 1'b0;
   logic               hwrite     = 1'b0;
   logic [1:0]         htrans     = 2'h0;
   logic [31:0]        haddr      = 32'h0;
   logic [31:0]        hwdata     = 32'h0;
   logic [6:0]         periph_req = 7'h00;
   logic [3:0]         lag        = 4'h0;
   logic               fail       = 1'b0;
   logic               hreadyout;
   logic               hresp;
   logic               xfer_valid;
   logic               xfer_done;
   logic               xfer_error;
   logic [31:0]        hrdata;
   logic [6:0]         irq;
   dmc_pkg::dmc_xfer_t xfer_req;
   dmc_pkg::dmc_xfer_t log_q[$];
   int                 miscompares = 0;
   int                 checks_done = 0;
   dmc_top u_dmc_top (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .periph_req, .xfer_valid, .xfer_req,
      .xfer_done, .xfer_error, .irq);
   dmc_mover_model u_dmc_mover_model (.clock, .reset, .xfer_valid, .lag, .fail, .xfer_done, .xfer_error);
   // The clock runs at 250 MHz.
   initial forever #2 clock = ~clock;
   // Log each item at the edge where the mover answers it.
   always @(posedge clock)
      if (xfer_valid && (xfer_done || xfer_error)) log_q.push_back(xfer_req);
   function automatic logic [11:0] ra(input logic [11:0] ofs, input int ch);
      return ofs + dmc_pkg::CH_STRIDE * ch[11:0];
   endfunction
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at time %h: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single word transfer; the master waits on ready, so slave latency is tolerated up to the 40-cycle limit.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      q = hrdata;
      if (n >= 40) begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   task automatic wait_items(input int n);
      int t;
      t = 0;
      while (log_q.size() < n && t < 400) begin
         @(posedge clock);
         t++;
      end
      if (t >= 400) begin
         miscompares++;
         tally_and_finish();
      end
      repeat (4) @(posedge clock);
   endtask
   task automatic t_setup();
      wr(ra(CTL, 2), 32'h0000_7FFE);
      rd_chk(ra(CTL, 2), 32'h0000_7FFE);
      wr(ra(CTL, 2), 32'hFFFF_8001);
      rd_chk(ra(CTL, 2), 32'h0000_0001);
      repeat (8) @(posedge clock);
      check(32'(log_q.size()), 32'h0);
      wr(ra(CTL, 2), 32'h0000_7FFE);
      rd_chk(ra(CTL, 2), 32'h0000_000E);
      rd_chk(12'h0FC, 32'h0);
      $display("test setup done");
   endtask
   task automatic t_mem();
      wr(ra(CNT, 0), 32'h2);
      wr(ra(PAD, 0), 32'h100);
      wr(ra(MAD, 0), 32'h200);
      wr(ra(CTL, 0), 32'h0000_49CF);
      wait_items(2);
      check(log_q[0].src_addr, 32'h100);
      check(log_q[1].src_addr, 32'h102);
      check(log_q[1].dst_addr, 32'h204);
      check({28'h0, log_q[0].src_size, log_q[0].dst_size}, 32'h6);
      rd_chk(ra(CNT, 0), 32'h0);
      rd_chk(FLG, 32'h7);
      check({25'h0, irq}, 32'h1);
      wr(FLG, 32'hFFFF_FFFF);
      rd_chk(FLG, 32'h7);
      wr(CLR, 32'h2);
      rd_chk(FLG, 32'h5);
      wr(CLR, 32'h1);
      rd_chk(FLG, 32'h0);
      check({25'h0, irq}, 32'h0);
      $display("test mem_copy done");
   endtask
   task automatic t_rank();
      logic [2:0] exp_ch[3] = '{3'h3, 3'h4, 3'h1};
      log_q.delete();
      lag <= 4'h2;
      wr(ra(MAD, 3), 32'h300);
      for (int c = 1; c < 5; c++)
         wr(ra(CNT, c), 32'h1);
      wr(ra(CTL, 1), 32'h1001);
      wr(ra(CTL, 3), 32'h3011);
      wr(ra(CTL, 4), 32'h3001);
      periph_req <= 7'h1A;
      wait_items(3);
      for (int i = 0; i < 3; i++)
         check({29'h0, log_q[i].channel}, {29'h0, exp_ch[i]});
      check(log_q[0].src_addr, 32'h300);
      rd_chk(FLG, 32'h0007_7070);
      periph_req <= 7'h00;
      lag <= 4'h0;
      wr(CLR, 32'h0001_1010);
      $display("test rank_order done");
   endtask
   task automatic t_err();
      log_q.delete();
      fail <= 1'b1;
      wr(ra(CNT, 5), 32'h3);
      wr(ra(CTL, 5), 32'h0000_4009);
      wait_items(1);
      repeat (10) @(posedge clock);
      check(32'(log_q.size()), 32'h1);
      rd_chk(FLG, 32'h0090_0000);
      rd_chk(ra(CTL, 5), 32'h0000_4008);
      rd_chk(ra(CNT, 5), 32'h3);
      check({25'h0, irq}, 32'h20);
      fail <= 1'b0;
      wr(CLR, 32'h0010_0000);
      $display("test bus_error done");
   endtask
   task automatic t_ring();
      log_q.delete();
      wr(ra(PAD, 6), 32'h40);
      wr(ra(CNT, 6), 32'h2);
      wr(ra(CTL, 6), 32'h0000_0063);
      periph_req <= 7'h40;
      wait_items(4);
      periph_req <= 7'h00;
      check(log_q[1].src_addr, 32'h41);
      check(log_q[2].src_addr, 32'h40);
      rd_chk(FLG, 32'h0700_0000);
      check({25'h0, irq}, 32'h40);
      $display("test ring done");
   endtask
   // Hold reset five cycles, then run every scenario.
   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd_chk(FLG, dmc_pkg::RESET_WORD);
      rd_chk(ra(CTL, 6), dmc_pkg::RESET_WORD);
      rd_chk(CLR, 32'h0);
      t_setup();
      t_mem();
      t_rank();
      t_err();
      t_ring();
      tally_and_finish();
   end
endmodule
`default_nettype wire
